// File: dtc_pkg.sv
package dtc_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h88;
    localparam logic [7:0] ADDR_MODE   = 8'h89;
    localparam logic [7:0] ADDR_A_LOW  = 8'h8A;
    localparam logic [7:0] ADDR_B_LOW  = 8'h8B;
    localparam logic [7:0] ADDR_A_HIGH = 8'h8C;
    localparam logic [7:0] ADDR_B_HIGH = 8'h8D;

    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] MODE_RESET  = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_IT_A  = 0;
    localparam int CTL_IE_A  = 1;
    localparam int CTL_TR_A  = 4;
    localparam int CTL_TF_A  = 5;
    localparam int CTL_STEP  = 2;
    localparam int MODE_LO   = 0;
    localparam int MODE_CT   = 2;
    localparam int MODE_GATE = 3;
    localparam int NIBBLE_W  = 4;
    localparam int PRESC_W   = 5;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int OSC_PER_MC = 6;

    typedef enum logic [1:0] {
        MODE_13BIT  = 2'b00,
        MODE_16BIT  = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT  = 2'b11
    } dtc_mode_t;

    typedef struct packed {
        logic [7:0]      ctrl;
        logic [7:0]      mode;
        logic [1:0][7:0] low;
        logic [1:0][7:0] high;
        logic [7:0]      rdData;
        logic            baudTick;
    } dtc_state_t;

endpackage

// File: dtc_pin_if.sv
`timescale 1ns/1ps
interface dtc_pin_if;
    logic       mcEn;
    logic [1:0] cntFall;
    logic [1:0] intLvl;
    logic [1:0] intFall;

    modport src (output mcEn, output cntFall, output intLvl, output intFall);
    modport dst (input mcEn, input cntFall, input intLvl, input intFall);
endinterface

// File: dtc_pin_sampler.sv
`timescale 1ns/1ps
module dtc_pin_sampler (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic [1:0] countPin,
    input  wire logic [1:0] extIrqPin,
    dtc_pin_if.src          pins
);

    typedef struct packed {
        logic [2:0] div;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [1:0] cntSamp;
        logic [1:0] intPrev;
        logic       mcEn;
        logic [1:0] cntFall;
        logic [1:0] intFall;
    } dtc_samp_t;

    localparam logic [2:0] DIV_LAST = 3'(dtc_pkg::OSC_PER_MC - 1);

    // Pins idle high, so the synchronisers start high and reset raises no level interrupt.
    localparam dtc_samp_t SAMP_RESET = '{sync1: 4'hF, sync2: 4'hF, cntSamp: 2'b11, intPrev: 2'b11, default: '0};

    dtc_samp_t s_q;
    dtc_samp_t s_d;

    // ------------------------------------------------------------
    // Sampling
    // ------------------------------------------------------------
    // The first sync stage feeds only the second; every decision uses the second stage.
    always_comb begin
        s_d = s_q;
        s_d.sync1 = {extIrqPin, countPin};
        s_d.sync2 = s_q.sync1;
        s_d.div = (s_q.div == DIV_LAST) ? 3'h0 : s_q.div + 3'h1;
        s_d.mcEn = (s_q.div == DIV_LAST); // [RULE3]
        s_d.intPrev = s_q.sync2[3:2];
        s_d.intFall = s_q.intPrev & ~s_q.sync2[3:2];
        s_d.cntFall = 2'b00;
        if (s_q.div == DIV_LAST) begin
            // Count pins are looked at once per machine cycle, so short glitches are missed.
            s_d.cntSamp = s_q.sync2[1:0]; // [RULE4]
            s_d.cntFall = s_q.cntSamp & ~s_q.sync2[1:0]; // [RULE4]
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= SAMP_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign pins.mcEn    = s_q.mcEn;
    assign pins.cntFall = s_q.cntFall;
    assign pins.intLvl  = s_q.sync2[3:2];
    assign pins.intFall = s_q.intFall;

endmodule

// File: dtc_timer_pair.sv
`timescale 1ns/1ps
// Functional notes
// [RULE1] Gate set: counter runs only while its irq pin is high and run bit set.
// [RULE2] Select bit clear counts machine cycles; set counts count-pin events.
// [RULE3] Timer mode increments once per machine cycle of six clocks.
// [RULE4] Count pin sampled per machine cycle; high then low sample increments.
// [RULE5] Two-bit mode field picks 13-bit, 16-bit, auto-reload or split mode.
// [RULE6] Mode 0 counts high byte plus low five bits as prescaler.
// [RULE7] Wrap from all ones to zero sets the counter's overflow flag.
// [RULE8] Setting a run bit never alters the held count.
// [RULE9] Gate of counter B is mode bit 7, of counter A bit 3.
// [RULE10] Mode 1 is a 16-bit counter, otherwise like mode 0.
// [RULE11] Mode 2 reloads low byte from high byte on overflow, high unchanged.
// [RULE12] Counter B in mode 3 stops and holds as if not running.
// [RULE13] Counter A mode 3: low byte is 8-bit counter with A controls.
// [RULE14] Counter A mode 3: high byte counts cycles, B run bit, B flag.
// [RULE15] With A in mode 3, B runs unless in mode 3; overflows feed baud.
// [RULE16] Overflow flags at control bits 7 and 5, set by hardware, cleared by ack/software.
// [RULE17] Run bits at control bits 6 and 4 are software written.
// [RULE18] External flags at bits 3 and 1 set on detect, cleared by ack/software.
// [RULE19] Type bits at 2 and 0 pick edge or level triggering.
// [RULE20] Type one selects falling edge, zero selects low level.
// [RULE21] Mode nibble holds gate, select, two-bit mode; upper nibble is counter B.
// [RULE22] Reset clears both control registers and both counters.
module dtc_timer_pair (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdData,
    input  wire logic       countPinA,
    input  wire logic       countPinB,
    input  wire logic       extIrqPinA,
    input  wire logic       extIrqPinB,
    input  wire logic       ovfAckA,
    input  wire logic       ovfAckB,
    input  wire logic       extAckA,
    input  wire logic       extAckB,
    output logic            counterAOverflowFlag,
    output logic            counterBOverflowFlag,
    output logic            extIrqAFlag,
    output logic            extIrqBFlag,
    output logic            baudTick
);

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    dtc_pin_if pinIf ();

    dtc_pin_sampler u_sampler (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .countPin  ({countPinB, countPinA}),
        .extIrqPin ({extIrqPinB, extIrqPinA}),
        .pins      (pinIf.src)
    );

    dtc_pkg::dtc_state_t s_q;
    dtc_pkg::dtc_state_t s_d;
    logic [1:0]          ovfSet;
    logic [1:0]          extSet;
    logic [1:0]          ovfAck;
    logic [1:0]          extAck;

    assign ovfAck = {ovfAckB, ovfAckA};
    assign extAck = {extAckB, extAckA};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic              gate;
        logic              sel;
        logic              run;
        logic              tick;
        logic              en;
        logic              wrap;
        logic              aSplit;
        logic [12:0]       c13;
        logic [15:0]       c16;
        dtc_pkg::dtc_mode_t md;
        gate   = 1'b0;
        sel    = 1'b0;
        run    = 1'b0;
        tick   = 1'b0;
        en     = 1'b0;
        wrap   = 1'b0;
        c13    = '0;
        c16    = '0;
        md     = dtc_pkg::MODE_13BIT;
        s_d    = s_q;
        ovfSet = 2'b00;
        extSet = 2'b00;
        s_d.baudTick = 1'b0;
        s_d.rdData   = 8'h00;
        aSplit = (s_q.mode[dtc_pkg::MODE_LO +: 2] == dtc_pkg::MODE_SPLIT); // [RULE5]

        for (int i = 0; i < 2; i++) begin
            gate = s_q.mode[i * dtc_pkg::NIBBLE_W + dtc_pkg::MODE_GATE]; // [RULE9] [RULE21]
            sel  = s_q.mode[i * dtc_pkg::NIBBLE_W + dtc_pkg::MODE_CT]; // [RULE21]
            md   = dtc_pkg::dtc_mode_t'(s_q.mode[i * dtc_pkg::NIBBLE_W + dtc_pkg::MODE_LO +: 2]); // [RULE5]
            run  = s_q.ctrl[dtc_pkg::CTL_TR_A + i * dtc_pkg::CTL_STEP]; // [RULE17]
            // While A is split, B's run bit belongs to A's high byte, so B runs on its mode alone.
            if (i == 1 && aSplit) begin
                run = 1'b1; // [RULE15]
            end
            if (i == 1 && md == dtc_pkg::MODE_SPLIT) begin
                run = 1'b0; // [RULE12]
            end
            tick = sel ? pinIf.cntFall[i] : pinIf.mcEn; // [RULE2] [RULE3] [RULE4]
            en   = run && (!gate || pinIf.intLvl[i]) && tick; // [RULE1] [RULE13]
            wrap = 1'b0;
            if (en) begin
                unique case (md)
                    dtc_pkg::MODE_13BIT: begin
                        // Upper three low-byte bits are left as they are and mean nothing here.
                        c13 = {s_q.high[i], s_q.low[i][dtc_pkg::PRESC_W-1:0]} + 13'h0001; // [RULE6]
                        s_d.high[i] = c13[12:dtc_pkg::PRESC_W];
                        s_d.low[i][dtc_pkg::PRESC_W-1:0] = c13[dtc_pkg::PRESC_W-1:0];
                        wrap = (c13 == 13'h0000); // [RULE7]
                    end
                    dtc_pkg::MODE_16BIT: begin
                        c16 = {s_q.high[i], s_q.low[i]} + 16'h0001; // [RULE10]
                        s_d.high[i] = c16[15:8];
                        s_d.low[i]  = c16[7:0];
                        wrap = (c16 == 16'h0000); // [RULE7]
                    end
                    dtc_pkg::MODE_RELOAD: begin
                        wrap = (s_q.low[i] == 8'hFF);
                        s_d.low[i] = wrap ? s_q.high[i] : s_q.low[i] + 8'h01; // [RULE11]
                    end
                    dtc_pkg::MODE_SPLIT: begin
                        s_d.low[i] = s_q.low[i] + 8'h01; // [RULE13]
                        wrap = (s_q.low[i] == 8'hFF);
                    end
                endcase
            end
            if (wrap) begin
                if (i == 1) begin
                    s_d.baudTick = 1'b1; // [RULE15]
                end
                if (!(i == 1 && aSplit)) begin
                    ovfSet[i] = 1'b1; // [RULE7]
                end
            end
        end

        // Split high byte of A: machine cycles only, no gate, B's run bit and flag.
        if (aSplit && s_q.ctrl[dtc_pkg::CTL_TR_A + dtc_pkg::CTL_STEP] && pinIf.mcEn) begin
            s_d.high[0] = s_q.high[0] + 8'h01; // [RULE14]
            if (s_q.high[0] == 8'hFF) begin
                ovfSet[1] = 1'b1; // [RULE14]
            end
        end

        // A write to a count byte overrides an increment landing in the same cycle.
        if (regWr) begin
            unique case (regAddr)
                dtc_pkg::ADDR_CTRL:   s_d.ctrl = regWrData; // [RULE8] [RULE17]
                dtc_pkg::ADDR_MODE:   s_d.mode = regWrData;
                dtc_pkg::ADDR_A_LOW:  s_d.low[0] = regWrData;
                dtc_pkg::ADDR_B_LOW:  s_d.low[1] = regWrData;
                dtc_pkg::ADDR_A_HIGH: s_d.high[0] = regWrData;
                dtc_pkg::ADDR_B_HIGH: s_d.high[1] = regWrData;
                default: ;
            endcase
        end
        if (regRd) begin
            unique case (regAddr)
                dtc_pkg::ADDR_CTRL:   s_d.rdData = s_q.ctrl;
                dtc_pkg::ADDR_MODE:   s_d.rdData = s_q.mode;
                dtc_pkg::ADDR_A_LOW:  s_d.rdData = s_q.low[0];
                dtc_pkg::ADDR_B_LOW:  s_d.rdData = s_q.low[1];
                dtc_pkg::ADDR_A_HIGH: s_d.rdData = s_q.high[0];
                dtc_pkg::ADDR_B_HIGH: s_d.rdData = s_q.high[1];
                default:              s_d.rdData = 8'h00;
            endcase
        end

        // Clears first, sets last, so an event in the clearing cycle is kept.
        for (int i = 0; i < 2; i++) begin
            if (ovfAck[i]) begin
                s_d.ctrl[dtc_pkg::CTL_TF_A + i * dtc_pkg::CTL_STEP] = 1'b0; // [RULE16]
            end
            if (extAck[i]) begin
                s_d.ctrl[dtc_pkg::CTL_IE_A + i * dtc_pkg::CTL_STEP] = 1'b0; // [RULE18]
            end
            extSet[i] = s_q.ctrl[dtc_pkg::CTL_IT_A + i * dtc_pkg::CTL_STEP]
                      ? pinIf.intFall[i] : !pinIf.intLvl[i]; // [RULE19] [RULE20]
            if (ovfSet[i]) begin
                s_d.ctrl[dtc_pkg::CTL_TF_A + i * dtc_pkg::CTL_STEP] = 1'b1; // [RULE16]
            end
            if (extSet[i]) begin
                s_d.ctrl[dtc_pkg::CTL_IE_A + i * dtc_pkg::CTL_STEP] = 1'b1; // [RULE18]
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_q.ctrl     <= dtc_pkg::CTRL_RESET; // [RULE22]
            s_q.mode     <= dtc_pkg::MODE_RESET; // [RULE22]
            s_q.low      <= {2{dtc_pkg::COUNT_RESET}}; // [RULE22]
            s_q.high     <= {2{dtc_pkg::COUNT_RESET}}; // [RULE22]
            s_q.rdData   <= 8'h00;
            s_q.baudTick <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign regRdData            = s_q.rdData;
    assign counterAOverflowFlag = s_q.ctrl[dtc_pkg::CTL_TF_A];
    assign counterBOverflowFlag = s_q.ctrl[dtc_pkg::CTL_TF_A + dtc_pkg::CTL_STEP];
    assign extIrqAFlag          = s_q.ctrl[dtc_pkg::CTL_IE_A];
    assign extIrqBFlag          = s_q.ctrl[dtc_pkg::CTL_IE_A + dtc_pkg::CTL_STEP];
    assign baudTick             = s_q.baudTick;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    a_mc_period: assert property ( // [RULE3]
        pinIf.mcEn |=> !pinIf.mcEn [*5] ##1 pinIf.mcEn)
        else $error("Machine cycle enable is not one in six clocks.");

    a_gate_blocks_a: assert property ( // [RULE1]
        (!regWr && s_q.mode[3] && !pinIf.intLvl[0] && s_q.mode[1:0] != 2'b11)
        |=> $stable({s_q.high[0], s_q.low[0]}))
        else $error("Gated counter A moved while its irq pin was low.");

    a_timer_tick_a: assert property ( // [RULE2]
        (!regWr && s_q.mode[3:0] == 4'h1 && s_q.ctrl[4] && pinIf.mcEn
         && {s_q.high[0], s_q.low[0]} != 16'hFFFF)
        |=> {s_q.high[0], s_q.low[0]} == $past({s_q.high[0], s_q.low[0]}) + 16'h0001)
        else $error("Counter A did not step on a machine cycle.");

    a_count_no_fall: assert property ( // [RULE4]
        (!regWr && s_q.mode[2] && s_q.mode[1:0] != 2'b11 && !pinIf.cntFall[0])
        |=> $stable({s_q.high[0], s_q.low[0]}))
        else $error("Counter A moved without a count pin fall.");

    a_mode0_wrap: assert property ( // [RULE6]
        (!regWr && s_q.mode[3:0] == 4'h0 && s_q.ctrl[4] && pinIf.mcEn
         && s_q.high[0] == 8'hFF && s_q.low[0][4:0] == 5'h1F)
        |=> s_q.ctrl[5] && s_q.high[0] == 8'h00 && s_q.low[0][4:0] == 5'h00)
        else $error("Mode 0 wrap did not clear count and set flag.");

    a_mode2_reload: assert property ( // [RULE11]
        (!regWr && s_q.mode[3:0] == 4'h2 && s_q.ctrl[4] && pinIf.mcEn && s_q.low[0] == 8'hFF)
        |=> s_q.low[0] == $past(s_q.high[0]) && $stable(s_q.high[0]) && s_q.ctrl[5])
        else $error("Mode 2 reload went wrong.");

    a_b_split_holds: assert property ( // [RULE12]
        (!regWr && s_q.mode[5:4] == 2'b11) |=> $stable({s_q.high[1], s_q.low[1]}))
        else $error("Counter B moved while in mode 3.");

    a_flag_set_wins: assert property ( // [RULE16]
        (ovfSet[0] && ovfAckA) |=> counterAOverflowFlag)
        else $error("Overflow lost to a clear in the same cycle.");

    a_level_irq: assert property ( // [RULE20]
        (!s_q.ctrl[0] && !pinIf.intLvl[0]) |=> extIrqAFlag)
        else $error("Low level did not raise the irq A flag.");

    a_stop_holds_a: assert property ( // [RULE17]
        (!regWr && !s_q.ctrl[4] && s_q.mode[1:0] != 2'b11)
        |=> $stable({s_q.high[0], s_q.low[0]}))
        else $error("Stopped counter A moved.");

    a_stop_holds_b: assert property ( // [RULE17]
        (!regWr && !s_q.ctrl[6] && s_q.mode[1:0] != 2'b11)
        |=> $stable({s_q.high[1], s_q.low[1]}))
        else $error("Stopped counter B moved.");

    a_gate_blocks_b: assert property ( // [RULE1]
        (!regWr && s_q.mode[7] && !pinIf.intLvl[1])
        |=> $stable({s_q.high[1], s_q.low[1]}))
        else $error("Gated counter B moved while its irq pin was low.");

    a_count_fall_b: assert property ( // [RULE4]
        (!regWr && s_q.mode[6] && !pinIf.cntFall[1])
        |=> $stable({s_q.high[1], s_q.low[1]}))
        else $error("Counter B moved without a count pin fall.");

    a_split_high_step: assert property ( // [RULE14]
        (!regWr && s_q.mode[1:0] == 2'b11 && s_q.ctrl[6] && pinIf.mcEn)
        |=> s_q.high[0] == $past(s_q.high[0]) + 8'h01)
        else $error("Split high byte did not step.");

    a_split_high_idle: assert property ( // [RULE14]
        (!regWr && s_q.mode[1:0] == 2'b11 && !(s_q.ctrl[6] && pinIf.mcEn))
        |=> $stable(s_q.high[0]))
        else $error("Split high byte moved without an enable.");

    a_reload_keeps_high: assert property ( // [RULE11]
        (!regWr && s_q.mode[1:0] == 2'b10)
        |=> $stable(s_q.high[0]))
        else $error("Reload mode changed the high byte.");

    a_mode1_wrap: assert property ( // [RULE10]
        (!regWr && s_q.mode[3:0] == 4'h1 && s_q.ctrl[4] && pinIf.mcEn && {s_q.high[0], s_q.low[0]} == 16'hFFFF)
        |=> counterAOverflowFlag && {s_q.high[0], s_q.low[0]} == 16'h0000)
        else $error("Mode 1 wrap did not clear count and set flag.");

    a_edge_irq_a: assert property ( // [RULE20]
        (s_q.ctrl[0] && pinIf.intFall[0])
        |=> extIrqAFlag)
        else $error("Falling edge did not raise the irq A flag.");

    a_edge_quiet_a: assert property ( // [RULE19]
        (!regWr && s_q.ctrl[0] && !s_q.ctrl[1] && !pinIf.intFall[0])
        |=> !extIrqAFlag)
        else $error("Irq A flag rose without a falling edge.");

    a_level_irq_b: assert property ( // [RULE20]
        (!s_q.ctrl[2] && !pinIf.intLvl[1])
        |=> extIrqBFlag)
        else $error("Low level did not raise the irq B flag.");

    a_ack_clears_a: assert property ( // [RULE16]
        (ovfAckA && !ovfSet[0])
        |=> !counterAOverflowFlag)
        else $error("Acknowledge did not clear overflow flag A.");

    a_ext_ack_b: assert property ( // [RULE18]
        (extAckB && !extSet[1])
        |=> !extIrqBFlag)
        else $error("Acknowledge did not clear the irq B flag.");

endmodule

// File: dtc_pin_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Far-side model of the count and interrupt pins
// ------------------------------------------------------------
module dtc_pin_model (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic [1:0] cntReq,
    input  wire logic [1:0] irqLevel,
    output logic      [1:0] countPin,
    output logic      [1:0] extIrqPin
);
    logic [1:0][4:0] busy_q;

    // A request gives a low of 8 clocks, then a high of at least 8 clocks.
    // Requests are ignored while busy, so no level is shorter than a machine cycle.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busy_q   <= '0;
            countPin <= 2'b11;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cntReq[i] && busy_q[i] == 5'h00) begin
                    busy_q[i]   <= 5'h10;
                    countPin[i] <= 1'b0;
                end else if (busy_q[i] != 5'h00) begin
                    busy_q[i]   <= busy_q[i] - 5'h01;
                    countPin[i] <= (busy_q[i] <= 5'h09);
                end
            end
        end
    end

    // The bench sets the interrupt levels, since gating scenarios need them held.
    assign extIrqPin = irqLevel;
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
    logic       mclk;
    logic       arst_n;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic       regWr;
    logic       regRd;
    logic [7:0] regRdData;
    logic [1:0] cntReq;
    logic [1:0] irqLevel;
    logic [1:0] countPin;
    logic [1:0] extIrqPin;
    logic [3:0] acks;
    wire  [4:0] obs;
    logic [7:0] rv;
    logic [7:0] ex;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] run;
    logic       hit;
    int         n_errors = 0;
    int         comparisons = 0;
    int         seed = 32'h930d_6c58;
    int         cycles = 0;
    int         n;
    time        t0;

    dtc_timer_pair dtc_timer_pair_i (.mclk(mclk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .countPinA(countPin[0]), .countPinB(countPin[1]),
        .extIrqPinA(extIrqPin[0]), .extIrqPinB(extIrqPin[1]), .ovfAckA(acks[0]), .ovfAckB(acks[1]),
        .extAckA(acks[2]), .extAckB(acks[3]), .counterAOverflowFlag(obs[0]), .counterBOverflowFlag(obs[1]),
        .extIrqAFlag(obs[2]), .extIrqBFlag(obs[3]), .baudTick(obs[4]));

    dtc_pin_model dtc_pin_model_i (.mclk(mclk), .arst_n(arst_n), .cntReq(cntReq), .irqLevel(irqLevel),
        .countPin(countPin), .extIrqPin(extIrqPin));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    always #20 mclk = ~mclk;

    // Mode 0 keeps only five low-byte bits of the count; the rest are indeterminate.
    function automatic logic [7:0] cntMask(input logic [7:0] m);
        return (m[1:0] == 2'b00) ? 8'h1f : 8'hff;
    endfunction

    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // The strobe is dropped and an edge passes, so no signal is set twice in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        @(negedge mclk);
        rv = regRdData;
        @(posedge mclk);
        chk(rv & (a == 8'h8a ? cntMask(ex) : 8'hff), exp);
    endtask

    task automatic waitBit(input int b, input int lim);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (obs[b] !== 1'b1 && n < lim);
        hit = obs[b];
        @(posedge mclk);
    endtask

    task automatic pulse(input int i);
        acks[i] <= 1'b1;
        @(posedge mclk);
        acks[i] <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic pinPulse(input int ch);
        cntReq[ch] <= 1'b1;
        @(posedge mclk);
        cntReq[ch] <= 1'b0;
        repeat (24) @(posedge mclk);
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        mclk = 0; arst_n = 0; regAddr = 0; regWrData = 0; regWr = 0;
        regRd = 0; cntReq = 0; irqLevel = 2'b11; acks = 0; ex = 8'hff;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        for (int a = 8'h88; a <= 8'h8d; a++) rdChk(8'(a), 8'h00);
        for (int i = 0; i < 4; i++) begin
            ex = $random(seed);
            lo = $random(seed) & 8'h7f;
            wr(8'h89, ex);
            wr(lo, 8'hff);
            rdChk(8'h89, ex);
            rdChk(lo, 8'h00);
        end
        ex = 8'hff;
        wr(8'h88, 8'h05);
        rdChk(8'h88, 8'h05);
        // Auto-reload period: two steps from 0xFE, one step per six clocks.
        wr(8'h89, 8'h02);
        wr(8'h8c, 8'hfe);
        wr(8'h8a, 8'hfe);
        wr(8'h88, 8'h10);
        waitBit(0, 20);
        t0 = $time;
        pulse(0);
        chk(obs[0], 1'b0);
        waitBit(0, 20);
        chk(8'(($time - t0) / 40), 8'd12);
        repeat (10) @(posedge mclk);
        pulse(0);
        chk(obs[0], 1'b1);
        wr(8'h88, 8'h00);
        rdChk(8'h8c, 8'hfe);
        for (int m = 0; m < 2; m++) begin
            ex = 8'(m);
            wr(8'h88, 8'h00);
            wr(8'h89, ex);
            wr(8'h8c, 8'hff);
            wr(8'h8a, m ? 8'hfe : 8'h1e);
            wr(8'h88, 8'h10);
            waitBit(0, 13);
            chk(hit, 1'b1);
            wr(8'h88, 8'h00);
            chk(obs[0], 1'b0);
            rdChk(8'h8c, 8'h00);
            rdChk(8'h8a, 8'h00);
        end
        ex = 8'hff;
        for (int ch = 0; ch < 2; ch++) begin
            lo = 8'h8a + 8'(ch);
            hi = 8'h8c + 8'(ch);
            run = ch ? 8'h40 : 8'h10;
            wr(8'h88, 8'h00);
            wr(8'h89, ch ? 8'h90 : 8'h09);
            wr(hi, 8'hff);
            wr(lo, 8'hff);
            irqLevel[ch] <= 1'b0;
            repeat (3) @(posedge mclk);
            wr(8'h88, run);
            waitBit(ch, 40);
            chk(hit, 1'b0);
            chk(obs[2 + ch], 1'b1);
            irqLevel[ch] <= 1'b1;
            waitBit(ch, 20);
            chk(hit, 1'b1);
            pulse(ch);
            chk(obs[ch], 1'b0);
            pulse(2 + ch);
            chk(obs[2 + ch], 1'b0);
            wr(8'h88, ch ? 8'h04 : 8'h01);
            irqLevel[ch] <= 1'b0;
            repeat (8) @(posedge mclk);
            chk(obs[2 + ch], 1'b1);
            wr(8'h88, ch ? 8'h04 : 8'h01);
            repeat (4) @(posedge mclk);
            chk(obs[2 + ch], 1'b0);
            irqLevel[ch] <= 1'b1;
            // Event counting in reload mode: three falls from 0xFD overflow once.
            wr(8'h88, 8'h00);
            wr(8'h89, ch ? 8'h60 : 8'h06);
            wr(hi, 8'hfd);
            wr(lo, 8'hfd);
            wr(8'h88, run);
            repeat (30) @(posedge mclk);
            rdChk(lo, 8'hfd);
            pinPulse(ch);
            pinPulse(ch);
            rdChk(lo, 8'hff);
            chk(obs[ch], 1'b0);
            pinPulse(ch);
            chk(obs[ch], 1'b1);
            rdChk(lo, 8'hfd);
        end
        // Split mode of the first counter and hold mode of the second.
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h30);
        wr(8'h8b, 8'h55);
        wr(8'h88, 8'h40);
        repeat (30) @(posedge mclk);
        rdChk(8'h8b, 8'h55);
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h13);
        wr(8'h8d, 8'hff);
        wr(8'h8b, 8'hff);
        waitBit(4, 12);
        chk(hit, 1'b1);
        chk(obs[1], 1'b0);
        wr(8'h89, 8'h33);
        wr(8'h8c, 8'hff);
        wr(8'h88, 8'h40);
        waitBit(1, 8);
        chk(hit, 1'b1);
        chk(obs[0], 1'b0);
        wr(8'h8a, 8'hff);
        wr(8'h88, 8'h10);
        waitBit(0, 8);
        chk(hit, 1'b1);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        for (int a = 8'h88; a <= 8'h8d; a++) rdChk(8'(a), 8'h00);
        final_report();
    end
endmodule
